// ===== fl_defs.svh
// constants for the serial flash pin block
`ifndef FL_DEFS_SVH
`define FL_DEFS_SVH
`define FL_CLK_MHZ 250
`define FL_RESET_MIN_NS 1000
`define FL_RESET_MIN_CYC ((`FL_RESET_MIN_NS * `FL_CLK_MHZ + 999) / 1000)
`define FL_RST_CNT_W 9
`define FL_SCLK_MAX_MHZ 104
`define FL_SAMPLE_MIN_CYC 8
`define FL_ADDR_W 24
`define FL_INSN_BITS 8
`define FL_BYTE_BITS 8
`define FL_PAGE_LSB 8
`define FL_SECTOR_LSB 12
`define FL_BLOCK_LSB 16
`define FL_ARRAY_LSB 18
`define FL_ARRAY_LAST 24'h03FFFF
`define FL_OE_OFF 4'hF
`endif

// ===== fl_pkg.sv
// types shared by the serial flash pin block
`include "fl_defs.svh"
package fl_pkg;
   typedef enum logic [2:0] {FL_PH_IDLE, FL_PH_INSN, FL_PH_CMD, FL_PH_ADDR, FL_PH_DATA} fl_phase_e;
   typedef enum logic [1:0] {FL_LANE_SINGLE, FL_LANE_DUAL, FL_LANE_QUAD} fl_lane_e;
   typedef enum logic [1:0] {FL_ER_SECTOR, FL_ER_BLOCK, FL_ER_CHIP} fl_erase_e;
   typedef struct packed {
      logic sclk_m;
      logic sclk_s;
      logic sclk_d;
      logic cs_m;
      logic cs_s;
      logic cs_d;
      logic [3:0] io_m;
      logic [3:0] io_s;
      logic armed;
      logic selected;
      logic hold_act;
      logic drv_on;
      fl_phase_e phase;
      fl_lane_e lane;
      logic is_read;
      logic wrap;
      logic [4:0] cnt;
      logic [`FL_ADDR_W-1:0] sh_in;
      logic [7:0] sh_out;
      logic [7:0] insn_byte;
      logic insn_valid;
      logic [`FL_ADDR_W-1:0] addr;
      logic [`FL_ADDR_W-1:0] cur_addr;
      logic addr_valid;
      logic [7:0] rx_byte;
      logic rx_valid;
      logic tx_next;
      logic [3:0] io_out;
      logic [3:0] io_oe_n;
      logic [`FL_RST_CNT_W-1:0] rst_cnt;
      logic hw_reset;
      logic [3:0] per_cnt;
      logic too_fast;
      logic sr_lock;
      logic prog_wr;
      logic [`FL_ADDR_W-1:0] prog_addr;
      logic [7:0] prog_data;
      logic erase_go;
      logic [`FL_ADDR_W-1:0] er_first;
      logic [`FL_ADDR_W-1:0] er_last;
      logic refused;
      logic [9:0] page;
      logic [5:0] sector;
      logic [1:0] block;
   } fl_st_s;
endpackage

// ===== fl_array_map.sv
// array organisation, protection range, program merge and erase span
`timescale 1ns/1ns
`include "fl_defs.svh"
module fl_array_map (
   input wire logic [`FL_ADDR_W-1:0] addr,
   input wire logic [2:0] bp,
   input wire logic tb,
   input wire logic sec,
   input wire logic cmp,
   input wire fl_pkg::fl_erase_e er_kind,
   input wire logic [7:0] old_byte,
   input wire logic [7:0] new_byte,
   output logic [9:0] page_idx,
   output logic [5:0] sector_idx,
   output logic [1:0] block_idx,
   output logic [`FL_ADDR_W-1:0] er_first,
   output logic [`FL_ADDR_W-1:0] er_last,
   output logic [7:0] merged,
   output logic prot,
   output logic er_prot
);
   logic [4:0] sz_lsb;
   logic [18:0] span;
   logic [18:0] off;
   logic in_rng;

   assign page_idx = addr[`FL_ARRAY_LSB-1:`FL_PAGE_LSB];
   assign sector_idx = addr[`FL_ARRAY_LSB-1:`FL_SECTOR_LSB];
   assign block_idx = addr[`FL_ARRAY_LSB-1:`FL_BLOCK_LSB];
   assign merged = old_byte & new_byte;

   always_comb begin
      sz_lsb = (sec ? 5'h0C : 5'h10) + {2'h0, bp} - 5'h01;
      span = (sz_lsb >= 5'h12) ? 19'h40000 : (19'h00001 << sz_lsb);
      off = {1'b0, addr[`FL_ARRAY_LSB-1:0]};
      if (tb) begin
         in_rng = off < span;
      end else begin
         in_rng = off >= (19'h40000 - span);
      end
      if (bp == 3'h0) begin
         in_rng = 1'b0;
      end
      prot = in_rng ^ cmp;
   end

   always_comb begin
      er_first = {addr[`FL_ADDR_W-1:`FL_SECTOR_LSB], 12'h000};
      er_last = {addr[`FL_ADDR_W-1:`FL_SECTOR_LSB], 12'hFFF};
      er_prot = prot;
      unique case (er_kind)
         fl_pkg::FL_ER_SECTOR: begin
         end
         fl_pkg::FL_ER_BLOCK: begin
            er_first = {addr[`FL_ADDR_W-1:`FL_BLOCK_LSB], 16'h0000};
            er_last = {addr[`FL_ADDR_W-1:`FL_BLOCK_LSB], 16'hFFFF};
         end
         fl_pkg::FL_ER_CHIP: begin
            er_first = 24'h000000;
            er_last = `FL_ARRAY_LAST;
            er_prot = (bp != 3'h0) || cmp;
         end
         default: begin
            er_prot = 1'b1;
         end
      endcase
   end
endmodule

// ===== fl_pins.sv
// serial flash pin front end: select, edges, shared pins, transfers
`timescale 1ns/1ns
`include "fl_defs.svh"
module fl_pins (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe_n,
   input wire logic quad_enable_bit,
   input wire logic pin3_function_select,
   input wire logic status_protect_bit,
   input wire logic block_protect_bit0,
   input wire logic block_protect_bit1,
   input wire logic block_protect_bit2,
   input wire logic top_bottom_select,
   input wire logic sector_block_select,
   input wire logic complement_protect,
   input wire logic cont_read_mode,
   input wire fl_pkg::fl_lane_e cmd_lane,
   input wire logic cmd_is_read,
   input wire logic cmd_has_addr,
   input wire logic cmd_page_wrap,
   input wire logic [7:0] tx_byte,
   input wire logic [`FL_ADDR_W-1:0] req_addr,
   input wire logic prog_req,
   input wire logic [7:0] prog_new,
   input wire logic [7:0] prog_old,
   input wire logic erase_req,
   input wire fl_pkg::fl_erase_e erase_kind,
   output logic [7:0] insn_byte,
   output logic insn_valid,
   output logic [`FL_ADDR_W-1:0] addr_out,
   output logic addr_valid,
   output logic [`FL_ADDR_W-1:0] cur_addr,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic tx_next,
   output logic hold_active,
   output logic hw_reset,
   output logic sr_write_locked,
   output logic sclk_too_fast,
   output logic prog_wr,
   output logic [`FL_ADDR_W-1:0] prog_wr_addr,
   output logic [7:0] prog_wr_data,
   output logic erase_go,
   output logic [`FL_ADDR_W-1:0] erase_first,
   output logic [`FL_ADDR_W-1:0] erase_last,
   output logic req_refused,
   output logic [9:0] req_page,
   output logic [5:0] req_sector,
   output logic [1:0] req_block
);
   fl_pkg::fl_st_s s_r;
   fl_pkg::fl_st_s s_nxt;
   logic rise;
   logic fall;
   logic cs_fall;
   logic hold_in;
   logic rst_low;
   logic [4:0] w;
   logic [`FL_ADDR_W-1:0] sh_tmp;
   logic [3:0] out_bits;
   logic [3:0] oe_mask;
   logic [`FL_ADDR_W-1:0] addr_inc;
   fl_pkg::fl_lane_e eff_lane;
   logic [9:0] m_page;
   logic [5:0] m_sector;
   logic [1:0] m_block;
   logic [`FL_ADDR_W-1:0] m_first;
   logic [`FL_ADDR_W-1:0] m_last;
   logic [7:0] m_merged;
   logic m_prot;
   logic m_er_prot;

   function automatic logic [4:0] lane_w(input fl_pkg::fl_lane_e ln);
      unique case (ln)
         fl_pkg::FL_LANE_DUAL: lane_w = 5'h02;
         fl_pkg::FL_LANE_QUAD: lane_w = 5'h04;
         default: lane_w = 5'h01;
      endcase
   endfunction

   function automatic logic [`FL_ADDR_W-1:0] shift_in(input logic [`FL_ADDR_W-1:0] sh,
                                                     input logic [3:0] io,
                                                     input fl_pkg::fl_lane_e ln);
      unique case (ln)
         fl_pkg::FL_LANE_DUAL: shift_in = {sh[`FL_ADDR_W-3:0], io[1:0]};
         fl_pkg::FL_LANE_QUAD: shift_in = {sh[`FL_ADDR_W-5:0], io[3:0]};
         default: shift_in = {sh[`FL_ADDR_W-2:0], io[0]};
      endcase
   endfunction

   assign rise = s_r.sclk_s & ~s_r.sclk_d;
   assign fall = ~s_r.sclk_s & s_r.sclk_d;
   assign cs_fall = s_r.cs_d & ~s_r.cs_s;
   assign w = lane_w(s_r.lane);
   assign sh_tmp = shift_in(s_r.sh_in, s_r.io_s, s_r.lane);
   // hold unless quad or reset select
   assign hold_in = !quad_enable_bit && !pin3_function_select && !s_r.io_s[3];
   // pin 3 as reset when selected and quad not enabled
   assign rst_low = !quad_enable_bit && pin3_function_select && !s_r.io_s[3];
   assign eff_lane = (cmd_lane == fl_pkg::FL_LANE_QUAD && !quad_enable_bit) ?
                     fl_pkg::FL_LANE_SINGLE : cmd_lane;
   assign addr_inc = s_r.wrap ?
                     {s_r.cur_addr[`FL_ADDR_W-1:`FL_PAGE_LSB], s_r.cur_addr[7:0] + 8'h01} :
                     s_r.cur_addr + 24'h000001;

   always_comb begin
      unique case (s_r.lane)
         fl_pkg::FL_LANE_DUAL: begin
            out_bits = {2'h0, s_r.sh_out[7:6]};
            oe_mask = 4'h3;
         end
         fl_pkg::FL_LANE_QUAD: begin
            out_bits = s_r.sh_out[7:4];
            oe_mask = 4'hF;
         end
         default: begin
            out_bits = {2'h0, s_r.sh_out[7], 1'b0};
            oe_mask = 4'h2;
         end
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.sclk_m = sclk;
      s_nxt.sclk_s = s_r.sclk_m;
      s_nxt.sclk_d = s_r.sclk_s;
      s_nxt.cs_m = cs_n;
      s_nxt.cs_s = s_r.cs_m;
      s_nxt.cs_d = s_r.cs_s;
      s_nxt.io_m = io_in;
      s_nxt.io_s = s_r.io_m;
      s_nxt.insn_valid = 1'b0;
      s_nxt.addr_valid = 1'b0;
      s_nxt.rx_valid = 1'b0;
      s_nxt.tx_next = 1'b0;
      s_nxt.hw_reset = 1'b0;
      s_nxt.prog_wr = 1'b0;
      s_nxt.erase_go = 1'b0;
      s_nxt.refused = 1'b0;
      s_nxt.hold_act = hold_in && !s_r.cs_s;
      s_nxt.sr_lock = status_protect_bit && !quad_enable_bit && !s_r.io_s[2];
      if (s_r.cs_s) begin
         s_nxt.armed = 1'b1;
      end
      if (rise) begin
         s_nxt.per_cnt = 4'h0;
      end else if (s_r.per_cnt != 4'hF) begin
         s_nxt.per_cnt = s_r.per_cnt + 4'h1;
      end
      if (s_r.cs_s) begin
         s_nxt.selected = 1'b0;
         s_nxt.phase = fl_pkg::FL_PH_IDLE;
         s_nxt.drv_on = 1'b0;
      end else if (cs_fall && s_r.armed) begin
         s_nxt.selected = 1'b1;
         s_nxt.cnt = 5'h00;
         s_nxt.too_fast = 1'b0;
         if (cont_read_mode) begin
            s_nxt.phase = fl_pkg::FL_PH_ADDR;
            s_nxt.lane = eff_lane;
            s_nxt.is_read = 1'b1;
            s_nxt.wrap = 1'b0;
         end else begin
            s_nxt.phase = fl_pkg::FL_PH_INSN;
            s_nxt.lane = fl_pkg::FL_LANE_SINGLE;
         end
      end else if (s_r.selected && !s_r.hold_act) begin
         unique case (s_r.phase)
            fl_pkg::FL_PH_IDLE: begin
            end
            fl_pkg::FL_PH_INSN: begin
               if (rise) begin
                  s_nxt.sh_in = sh_tmp;
                  s_nxt.cnt = s_r.cnt + 5'h01;
                  if (s_r.cnt == 5'(`FL_INSN_BITS - 1)) begin
                     s_nxt.insn_byte = sh_tmp[7:0];
                     s_nxt.insn_valid = 1'b1;
                     s_nxt.phase = fl_pkg::FL_PH_CMD;
                     s_nxt.cnt = 5'h00;
                  end
               end
            end
            fl_pkg::FL_PH_CMD: begin
               s_nxt.lane = eff_lane;
               s_nxt.is_read = cmd_is_read;
               s_nxt.wrap = cmd_page_wrap;
               s_nxt.phase = cmd_has_addr ? fl_pkg::FL_PH_ADDR : fl_pkg::FL_PH_DATA;
               if (!cmd_has_addr && cmd_is_read) begin
                  s_nxt.sh_out = tx_byte;
                  s_nxt.tx_next = 1'b1;
               end
            end
            fl_pkg::FL_PH_ADDR: begin
               if (rise) begin
                  s_nxt.sh_in = sh_tmp;
                  s_nxt.cnt = s_r.cnt + w;
                  if (s_r.cnt + w == 5'(`FL_ADDR_W)) begin
                     s_nxt.addr = sh_tmp;
                     s_nxt.cur_addr = sh_tmp;
                     s_nxt.addr_valid = 1'b1;
                     s_nxt.phase = fl_pkg::FL_PH_DATA;
                     s_nxt.cnt = 5'h00;
                     if (s_r.is_read) begin
                        s_nxt.sh_out = tx_byte;
                        s_nxt.tx_next = 1'b1;
                     end
                  end
               end
            end
            fl_pkg::FL_PH_DATA: begin
               if (s_r.is_read) begin
                  if (fall) begin
                     s_nxt.drv_on = 1'b1;
                     s_nxt.io_out = out_bits;
                     s_nxt.sh_out = s_r.sh_out << w;
                     s_nxt.cnt = s_r.cnt + w;
                     if (s_r.cnt + w == 5'(`FL_BYTE_BITS)) begin
                        s_nxt.sh_out = tx_byte;
                        s_nxt.tx_next = 1'b1;
                        s_nxt.cnt = 5'h00;
                        s_nxt.cur_addr = addr_inc;
                     end
                  end
               end else if (rise) begin
                  s_nxt.sh_in = sh_tmp;
                  s_nxt.cnt = s_r.cnt + w;
                  if (s_r.cnt + w == 5'(`FL_BYTE_BITS)) begin
                     s_nxt.rx_byte = sh_tmp[7:0];
                     s_nxt.rx_valid = 1'b1;
                     s_nxt.cnt = 5'h00;
                     s_nxt.cur_addr = addr_inc;
                  end
               end
            end
            default: begin
               s_nxt.phase = fl_pkg::FL_PH_IDLE;
            end
         endcase
      end
      if (rise && s_r.selected && s_r.per_cnt < 4'(`FL_SAMPLE_MIN_CYC - 1)) begin
         s_nxt.too_fast = 1'b1;
      end
      if (rst_low) begin
         if (s_r.rst_cnt != `FL_RST_CNT_W'(`FL_RESET_MIN_CYC)) begin
            s_nxt.rst_cnt = s_r.rst_cnt + `FL_RST_CNT_W'(1);
         end
      end else begin
         s_nxt.rst_cnt = '0;
      end
      if (s_nxt.rst_cnt == `FL_RST_CNT_W'(`FL_RESET_MIN_CYC)) begin
         s_nxt.hw_reset = s_r.rst_cnt != `FL_RST_CNT_W'(`FL_RESET_MIN_CYC);
         s_nxt.selected = 1'b0;
         s_nxt.phase = fl_pkg::FL_PH_IDLE;
         s_nxt.drv_on = 1'b0;
         s_nxt.armed = 1'b0;
      end
      s_nxt.io_oe_n = ~(oe_mask & {4{s_nxt.drv_on && !s_nxt.hold_act && s_nxt.selected}});
      s_nxt.page = m_page;
      s_nxt.sector = m_sector;
      s_nxt.block = m_block;
      if (prog_req) begin
         s_nxt.refused = m_prot;
         s_nxt.prog_wr = !m_prot;
         s_nxt.prog_addr = req_addr;
         s_nxt.prog_data = m_merged;
      end else if (erase_req) begin
         s_nxt.refused = m_er_prot;
         s_nxt.erase_go = !m_er_prot;
         s_nxt.er_first = m_first;
         s_nxt.er_last = m_last;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.io_oe_n <= `FL_OE_OFF;
      end else begin
         s_r <= s_nxt;
      end
   end

   fl_array_map u_map (
      .addr(req_addr),
      .bp({block_protect_bit2, block_protect_bit1, block_protect_bit0}),
      .tb(top_bottom_select),
      .sec(sector_block_select),
      .cmp(complement_protect),
      .er_kind(erase_kind),
      .old_byte(prog_old),
      .new_byte(prog_new),
      .page_idx(m_page),
      .sector_idx(m_sector),
      .block_idx(m_block),
      .er_first(m_first),
      .er_last(m_last),
      .merged(m_merged),
      .prot(m_prot),
      .er_prot(m_er_prot)
   );

   assign io_out = s_r.io_out;
   assign io_oe_n = s_r.io_oe_n;
   assign insn_byte = s_r.insn_byte;
   assign insn_valid = s_r.insn_valid;
   assign addr_out = s_r.addr;
   assign addr_valid = s_r.addr_valid;
   assign cur_addr = s_r.cur_addr;
   assign rx_byte = s_r.rx_byte;
   assign rx_valid = s_r.rx_valid;
   assign tx_next = s_r.tx_next;
   assign hold_active = s_r.hold_act;
   assign hw_reset = s_r.hw_reset;
   assign sr_write_locked = s_r.sr_lock;
   assign sclk_too_fast = s_r.too_fast;
   assign prog_wr = s_r.prog_wr;
   assign prog_wr_addr = s_r.prog_addr;
   assign prog_wr_data = s_r.prog_data;
   assign erase_go = s_r.erase_go;
   assign erase_first = s_r.er_first;
   assign erase_last = s_r.er_last;
   assign req_refused = s_r.refused;
   assign req_page = s_r.page;
   assign req_sector = s_r.sector;
   assign req_block = s_r.block;
endmodule

// ===== fl_pins_properties.sv
// port assertions for the serial flash pin block
`timescale 1ns/1ns
`include "fl_defs.svh"
module fl_pins_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic quad_enable_bit,
   input wire logic pin3_function_select,
   input wire logic [3:0] io_oe_n,
   input wire logic hold_active,
   input wire logic hw_reset,
   input wire logic prog_req,
   input wire logic erase_req,
   input wire logic [7:0] prog_new,
   input wire logic [7:0] prog_old,
   input wire logic [`FL_ADDR_W-1:0] req_addr,
   input wire logic prog_wr,
   input wire logic [7:0] prog_wr_data,
   input wire logic erase_go,
   input wire logic req_refused,
   input wire logic [9:0] req_page,
   input wire logic [5:0] req_sector,
   input wire logic [1:0] req_block
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_deselect_float: assert property (cs_n [*6] |-> io_oe_n == `FL_OE_OFF)
      else $error("outputs driven while deselected");
   a_hold_float: assert property (hold_active [*2] |-> io_oe_n == `FL_OE_OFF)
      else $error("outputs driven during hold");
   a_hold_role: assert property (hold_active |-> !pin3_function_select && !quad_enable_bit)
      else $error("hold in wrong pin mode");
   a_reset_role: assert property (hw_reset |-> pin3_function_select && !quad_enable_bit)
      else $error("pin reset in wrong pin mode");
   a_reset_once: assert property (hw_reset |=> !hw_reset [*8])
      else $error("pin reset pulsed twice");
   a_req_answer: assert property (prog_req || erase_req |=> prog_wr || erase_go || req_refused)
      else $error("request not answered");
   a_no_spurious: assert property (!prog_req && !erase_req |=> !prog_wr && !erase_go && !req_refused)
      else $error("answer without request");
   a_prog_merge: assert property (prog_wr |-> prog_wr_data == ($past(prog_old) & $past(prog_new)))
      else $error("program sets bits");
   a_index_map: assert property (1'b1 |=> req_sector == $past(req_addr[17:12])
      && req_page == $past(req_addr[17:8]) && req_block == $past(req_addr[17:16]))
      else $error("array index wrong");
   c_hold: cover property (hold_active);
   c_reset: cover property (hw_reset);
   c_refuse: cover property (req_refused);
endmodule
bind fl_pins fl_pins_chk fl_pins_chk_i (.clk, .rst_n, .cs_n, .quad_enable_bit,
   .pin3_function_select, .io_oe_n, .hold_active, .hw_reset, .prog_req, .erase_req, .prog_new,
   .prog_old, .req_addr, .prog_wr, .prog_wr_data, .erase_go, .req_refused, .req_page,
   .req_sector, .req_block);

// ===== fl_host_model.sv
// host serial controller model driving the flash pins
`timescale 1ns/1ns
module fl_host_model (
   output logic sclk,
   output logic cs_n,
   output logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe_n
);
   logic [3:0] host_en;
   logic [3:0] host_val;
   logic [7:0] rx;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      host_en = 4'h0;
      host_val = 4'h0;
      rx = 8'h00;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (!io_oe_n[i]) io_in[i] = io_out[i];
         else if (host_en[i]) io_in[i] = host_val[i];
         else io_in[i] = (i >= 2) ? 1'b1 : ~host_val[i];
      end
   end
   task automatic set_pin(input int i, input logic en, input logic v);
      host_en[i] <= en;
      host_val[i] <= v;
   endtask
   task automatic start();
      #1;
      cs_n = 1'b1;
      #40;
      cs_n = 1'b0;
      #40;
   endtask
   task automatic stop();
      #40;
      cs_n = 1'b1;
      host_en = 4'h0;
      #200;
   endtask
   task automatic shift(input logic [7:0] tx, input int nb, input int w, input bit rd);
      logic [7:0] d;
      d = tx;
      for (int k = 0; k < nb; k += w) begin
         for (int j = 0; j < w; j++) begin
            host_en[j] = !rd;
            host_val[j] = d[8-w+j];
         end
         d = d << w;
         #32 sclk = 1'b1;
         if (rd) rx = (rx << w) | 8'(w == 4 ? io_in : w == 2 ? {2'b00, io_in[1:0]} : {3'b000, io_in[1]});
         #32 sclk = 1'b0;
      end
   endtask
endmodule

// ===== test_multi_io_serial_flash_pins.sv
// self-checking bench for the serial flash pin block
`timescale 1ns/1ns
module test_multi_io_serial_flash_pins;
   logic clk, rst_n, qe, p3s, srp, is_rd, prog_req, erase_req, crm, too_fast;
   logic [3:0] ev;
   int n_ev[4];
   logic sclk, cs_n, hold_active, hw_reset, sr_write_locked, prog_wr, erase_go, req_refused;
   logic [3:0] io_in, io_out, io_oe_n;
   logic [5:0] pv;
   logic [7:0] tx_byte, prog_new, prog_old, insn_byte, rx_byte, prog_wr_data;
   logic [23:0] req_addr, addr_out, cur_addr, prog_wr_addr, erase_first, erase_last;
   fl_pkg::fl_lane_e lane;
   fl_pkg::fl_erase_e ek;
   int n_fail, total_checks, n_rst;
   fl_pins fl_pins_i (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
      .io_out(io_out), .io_oe_n(io_oe_n), .quad_enable_bit(qe), .pin3_function_select(p3s),
      .status_protect_bit(srp), .block_protect_bit0(pv[0]), .block_protect_bit1(pv[1]),
      .block_protect_bit2(pv[2]), .top_bottom_select(pv[3]), .sector_block_select(pv[4]),
      .complement_protect(pv[5]), .cont_read_mode(crm), .cmd_lane(lane), .cmd_is_read(is_rd),
      .cmd_has_addr(1'b1), .cmd_page_wrap(1'b0), .tx_byte(tx_byte), .req_addr(req_addr),
      .prog_req(prog_req), .prog_new(prog_new), .prog_old(prog_old), .erase_req(erase_req),
      .erase_kind(ek), .insn_byte(insn_byte), .insn_valid(ev[3]), .addr_out(addr_out),
      .addr_valid(ev[2]), .cur_addr(cur_addr), .rx_byte(rx_byte), .rx_valid(ev[1]),
      .tx_next(ev[0]),
      .hold_active(hold_active), .hw_reset(hw_reset), .sr_write_locked(sr_write_locked),
      .sclk_too_fast(too_fast), .prog_wr(prog_wr), .prog_wr_addr(prog_wr_addr),
      .prog_wr_data(prog_wr_data), .erase_go(erase_go), .erase_first(erase_first),
      .erase_last(erase_last), .req_refused(req_refused), .req_page(), .req_sector(),
      .req_block());
   fl_host_model host_i (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
      .io_oe_n(io_oe_n));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (hw_reset === 1'b1) n_rst++;
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (ev[i] === 1'b1) n_ev[i]++;
      end
   end
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (n_fail == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic head(input bit rd, input int w, input logic [7:0] d);
      @(posedge clk);
      is_rd <= rd;
      tx_byte <= d;
      host_i.start();
      host_i.shift(8'hA5, 8, 1, 1'b0);
      chk("insn", 24'(insn_byte), 24'hA5);
      for (int b = 2; b >= 0; b--) host_i.shift(8'(24'h012345 >> (8 * b)), 8, w, 1'b0);
      chk("addr", addr_out, 24'h012345);
   endtask
   task automatic req(input int k, input logic [23:0] a, input logic [5:0] p,
      input logic [2:0] exp, input logic [23:0] ef, input logic [23:0] el);
      @(posedge clk);
      pv <= p;
      req_addr <= a;
      prog_req <= (k == 0);
      erase_req <= (k != 0);
      ek <= fl_pkg::fl_erase_e'(k == 0 ? 0 : k - 1);
      @(posedge clk);
      prog_req <= 1'b0;
      erase_req <= 1'b0;
      #1;
      chk("answer", 24'({prog_wr, erase_go, req_refused}), 24'(exp));
      if (k == 0 && exp[2]) chk("prog data", 24'(prog_wr_data), 24'h0C);
      if (k == 0 && exp[2]) chk("prog addr", prog_wr_addr, a);
      if (k != 0 && exp[1]) chk("erase first", erase_first, ef);
      if (k != 0 && exp[1]) chk("erase last", erase_last, el);
   endtask
   initial begin
      {rst_n, qe, p3s, srp, is_rd, prog_req, erase_req, crm, pv, tx_byte, req_addr} = '0;
      lane = fl_pkg::FL_LANE_SINGLE;
      ek = fl_pkg::FL_ER_SECTOR;
      prog_new = 8'h0F;
      prog_old = 8'h3C;
      {n_fail, total_checks, n_rst} = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int L = 0; L < 3; L++) begin
         @(posedge clk);
         lane <= fl_pkg::fl_lane_e'(L);
         qe <= (L == 2);
         for (int r = 1; r >= 0; r--) begin
            n_ev = '{default: 0};
            head(r[0], 1 << L, 8'hC6 + 8'(L * 3 + r));
            for (int b = 0; b < 2; b++) begin
               host_i.shift(8'hC6 + 8'(L * 3 + r), 8, 1 << L, r[0]);
               if (r == 1) chk("read", 24'(host_i.rx), 24'hC6 + 24'(L * 3 + r));
            end
            if (r == 0) chk("write", 24'(rx_byte), 24'hC6 + 24'(L * 3));
            host_i.stop();
            chk("cur addr", cur_addr, 24'h012347);
            chk("float", 24'(io_oe_n), 24'hF);
            chk("pulses", 24'({4'(n_ev[3]), 4'(n_ev[2]), 4'(n_ev[1]), 4'(n_ev[0])}),
               (r == 1) ? 24'h1103 : 24'h1120);
            chk("too fast", 24'(too_fast), 24'h0);
         end
      end
      @(posedge clk);
      lane <= fl_pkg::FL_LANE_SINGLE;
      qe <= 1'b0;
      head(1'b0, 1, 8'h00);
      host_i.shift(8'hA0, 4, 1, 1'b0);
      host_i.set_pin(3, 1'b1, 1'b0);
      host_i.shift(8'hFF, 8, 1, 1'b0);
      chk("hold", 24'({hold_active, io_oe_n}), 24'h1F);
      host_i.set_pin(3, 1'b0, 1'b0);
      #100;
      host_i.shift(8'h50, 4, 1, 1'b0);
      chk("resume", 24'(rx_byte), 24'hA5);
      host_i.stop();
      @(posedge clk);
      crm <= 1'b1;
      tx_byte <= 8'h96;
      host_i.start();
      for (int b = 2; b >= 0; b--) host_i.shift(8'(24'h02A5C3 >> (8 * b)), 8, 1, 1'b0);
      chk("cont addr", addr_out, 24'h02A5C3);
      host_i.shift(8'h00, 8, 1, 1'b1);
      chk("cont read", 24'(host_i.rx), 24'h96);
      chk("cont cur addr", cur_addr, 24'h02A5C4);
      host_i.stop();
      @(posedge clk);
      crm <= 1'b0;
      req(0, 24'h012345, 6'h00, 3'b100, 24'h0, 24'h0);
      req(1, 24'h012345, 6'h00, 3'b010, 24'h012000, 24'h012FFF);
      req(2, 24'h012345, 6'h00, 3'b010, 24'h010000, 24'h01FFFF);
      req(3, 24'h012345, 6'h00, 3'b010, 24'h000000, 24'h03FFFF);
      req(0, 24'h030000, 6'h01, 3'b001, 24'h0, 24'h0);
      req(0, 24'h02FFFF, 6'h01, 3'b100, 24'h0, 24'h0);
      req(3, 24'h012345, 6'h01, 3'b001, 24'h0, 24'h0);
      req(0, 24'h00FFFF, 6'h09, 3'b001, 24'h0, 24'h0);
      req(1, 24'h03EFFF, 6'h11, 3'b010, 24'h03E000, 24'h03EFFF);
      req(0, 24'h03F000, 6'h11, 3'b001, 24'h0, 24'h0);
      req(0, 24'h012345, 6'h21, 3'b001, 24'h0, 24'h0);
      for (int q = 0; q < 3; q++) begin
         @(posedge clk);
         qe <= (q == 1);
         p3s <= 1'b1;
         srp <= 1'b1;
         n_rst = 0;
         host_i.set_pin(2, 1'b1, 1'b0);
         repeat (8) @(posedge clk);
         chk("wp lock", 24'(sr_write_locked), 24'(q != 1));
         // pin held past or short of minimum
         host_i.set_pin(3, 1'b1, 1'b0);
         repeat (q == 2 ? 200 : 300) @(posedge clk);
         host_i.set_pin(3, 1'b0, 1'b0);
         host_i.set_pin(2, 1'b0, 1'b0);
         repeat (8) @(posedge clk);
         chk("pin reset", 24'(n_rst), 24'(q == 0));
      end
      complete_run();
   end
   initial begin
      #200000;
      n_fail++;
      complete_run();
   end
endmodule
